// ===== pkg/adc_cycle_pkg.sv
// Shared constants, states and carriers of the converter cycle controller
package adc_cycle_pkg;

    // ==========================================================
    // Serial word
    localparam int         WORD_BITS    = 32;
    localparam logic [5:0] WORD_LAST    = 6'h1F;
    localparam logic [5:0] WORD_FULL    = 6'h20;
    localparam int         BIT_EOC      = 31;
    localparam int         BIT_FIXED    = 30;
    localparam int         BIT_SIGN     = 29;
    localparam int         BIT_MSB      = 28;

    // ==========================================================
    // Selection word fields, numbered as first bit in = bit 31
    localparam int         SEL_EN_POS   = 31;
    localparam int         SEL_GREF_POS = 30;
    localparam int         SEL_CH_POS   = 26;
    localparam int         SEL_OSR_POS  = 23;
    localparam int         SEL_TWOX_POS = 22;
    localparam logic [5:0] SDI_MIN_BITS = 6'h0A;

    // ==========================================================
    // Values after reset
    localparam logic [3:0] CH_DEFAULT   = 4'h0;
    localparam logic       GREF_DEFAULT = 1'b0;
    localparam logic [2:0] OSR_DEFAULT  = 3'h0;
    localparam logic       TWOX_DEFAULT = 1'b0;

    // ==========================================================
    // Pin positions in the synchroniser vector
    localparam int PIN_CS  = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_SEL = 3;
    localparam int PIN_F0  = 4;
    localparam int PIN_N   = 5;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          ISCK_PERIOD_NS = 1111;
    localparam int          ISCK_HALF_CYC  = (ISCK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int          CONV_TIME_NS   = 1130000;
    localparam int          CONV_CYC       = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int          F0_IDLE_NS     = 10000;
    localparam int          F0_IDLE_CYC    = (F0_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OSR_BASE       = 256;
    localparam int          EOSC_PER_OSR   = 40;
    localparam logic [31:0] EOSC_BASE      = 32'(EOSC_PER_OSR * OSR_BASE);
    localparam logic [31:0] EOSC_FIXED     = 32'h0000_00B2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {PH_CONVERT, PH_SLEEP, PH_OUTPUT} phase_e;

    typedef struct packed {
        logic [3:0] chan;
        logic       gref;
        logic [2:0] oversampling_ratio;
        logic       twox;
    } cfg_s;

    typedef struct packed {
        logic        sign;
        logic [23:0] value;
        logic [4:0]  sub;
        logic        over;
        logic        under;
    } res_s;

endpackage

// ===== core/adc_cycle_ctrl.sv
// Cycle sequencer, serial port and result buffer of the converter
`timescale 1ns/1ps

// ==========================================================
// What this block does
// RQ1 - Busy high converting, low until next conversion
// RQ2 - Select pin low: host drives serial clock
// RQ3 - Select pin high: device drives serial clock
// RQ4 - Host word sets next conversion settings
// RQ5 - Reset defaults: first pair, ratio 256, 1x
// RQ6 - Update bit low keeps previous settings
// RQ7 - Input bits sampled during data output
// RQ8 - First conversion after change is valid
// RQ9 - Tied frequency pin: internal oscillator timing
// RQ10 - Chip select low enables output, wakes
// RQ11 - Sleep after conversion while select high
// RQ12 - Select high during output aborts, converts
// RQ13 - Select high: data output high impedance
// RQ14 - Data pin shows conversion status otherwise
// RQ15 - Clock pin direction follows select pin
// RQ16 - Convert, sleep, output, repeated forever
// RQ17 - Result held unchanged throughout sleep
// RQ18 - 1x mode outputs just completed result
// RQ19 - Data changes on falling clock edges
// RQ20 - Output ends after 32 bits, then converts
// RQ21 - Distinct codes for over and under range
// RQ22 - One bit selects global reference pair
// RQ23 - Word: status, 24-bit result, 5 sub bits
// RQ24 - Sign and MSB equal flag range faults
// RQ25 - 32nd falling edge drives data high
// RQ26 - Host may clock frequency pin externally
// RQ27 - Selection word layout held as constants

// ==========================================================
// Result buffer between front end and output shifter
module result_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    import adc_cycle_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    rdy;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    // Ready is registered so the top output comes from a flop
    always_comb begin
        d    = q;
        push = in_valid && q.rdy;
        pop  = out_valid && out_ready;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        d.rdy = (d.cnt != CW'(DEPTH));
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Drain side view
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign in_ready  = q.rdy;

endmodule // result_fifo

// ==========================================================
// Top: cycle sequencer and serial port
module adc_cycle_ctrl #(
    parameter int CONV_LEN   = adc_cycle_pkg::CONV_CYC,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                 CLOCK,
    input  wire logic                 NRST,
    // Serial pins
    input  wire logic                 CS_N,
    input  wire logic                 SDI,
    input  wire logic                 SCK_I,
    output logic                      SCK_O,
    output logic                      SCK_OE,
    output logic                      SDO_O,
    output logic                      SDO_OE,
    output logic                      BUSY,
    // Mode pins
    input  wire logic                 SCK_SOURCE_SELECT,
    input  wire logic                 CONVERSION_CLOCK_PIN,
    // Front end control
    output logic                      CONV_START,
    output adc_cycle_pkg::cfg_s       CONV_CFG,
    output logic                      OSC_EXTERNAL,
    output logic                      SLEEP,
    // Front end results
    input  wire logic                 RES_VALID,
    input  wire adc_cycle_pkg::res_s  RES_DATA,
    output logic                      RES_READY
);
    import adc_cycle_pkg::*;

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        logic [PIN_N-1:0] flt;
        phase_e           ph;
        logic             kick;
        logic [31:0]      tmr;
        logic             run_ext;
        logic [7:0]       f0_idle;
        logic             f0_ext;
        cfg_s             cfg;
        logic [31:0]      sreg;
        logic [31:0]      sdi_w;
        logic [5:0]       fcnt;
        logic [5:0]       rcnt;
        logic [4:0]       div;
        logic             sck_o;
        logic             sck_oe;
        logic             sdo_o;
        logic             sdo_oe;
        logic             busy;
        logic             start;
        logic             sleep;
    } st_s;

    st_s              q;
    st_s              d;
    logic [PIN_N-1:0] agree;
    logic             cs_n;
    logic             int_sck;
    logic             rise;
    logic             fall;
    logic             f0_rise;
    logic             tick;
    logic             pop;
    logic             fifo_ov;
    res_s             fifo_res;

    // Conversion length in clocks or in frequency-pin edges
    function automatic logic [31:0] conv_ticks(input logic [2:0] oversampling_ratio,
                                               input logic sck_source_select);
        logic [31:0] base;
        base = sck_source_select ? EOSC_BASE : 32'(CONV_LEN);
        conv_ticks = (base << oversampling_ratio) + (sck_source_select ? EOSC_FIXED : 32'h0000_0000);
    endfunction

    // Output word with status bits and range codes
    function automatic logic [31:0] out_word(input res_s r);
        logic [31:0] w;
        w = {2'b00, r.sign, r.value, r.sub}; // RQ23
        w[BIT_EOC]   = 1'b0;
        w[BIT_FIXED] = 1'b0;
        if (r.over) begin
            w[BIT_SIGN] = 1'b1; // RQ21 RQ24
            w[BIT_MSB]  = 1'b1; // RQ24
        end else if (r.under) begin
            w[BIT_SIGN] = 1'b0; // RQ21 RQ24
            w[BIT_MSB]  = 1'b0; // RQ24
        end
        out_word = w;
    endfunction

    // Results queue up here; its ready stalls the front end
    result_fifo #(
        .W     ($bits(res_s)),
        .DEPTH (FIFO_DEPTH)
    ) result_fifo_inst (
        .clk       (CLOCK),
        .nrst      (NRST),
        .in_valid  (RES_VALID),
        .in_data   (RES_DATA),
        .in_ready  (RES_READY),
        .out_valid (fifo_ov),
        .out_data  (fifo_res),
        .out_ready (pop)
    );

    // Next state of the whole controller
    always_comb begin
        d       = q;
        d.start = 1'b0;
        pop     = 1'b0;

        // Pins: a change counts once stages two and three agree
        d.s1  = {CONVERSION_CLOCK_PIN, SCK_SOURCE_SELECT, SDI, SCK_I, CS_N};
        d.s2  = q.s1;
        d.s3  = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.flt = (agree & q.s3) | (~agree & q.flt);
        cs_n  = d.flt[PIN_CS];

        // Frequency pin counts as a clock only while it toggles
        f0_rise = d.flt[PIN_F0] & ~q.flt[PIN_F0];
        if (f0_rise) begin
            d.f0_idle = 8'h00;
        end else if (q.f0_idle != 8'hFF) begin
            d.f0_idle = q.f0_idle + 1'b1;
        end
        d.f0_ext = (d.f0_idle < 8'(F0_IDLE_CYC)); // RQ9 RQ26

        // Serial clock source follows the select pin
        int_sck = d.flt[PIN_SEL]; // RQ2 RQ3 RQ15
        rise    = 1'b0;
        fall    = 1'b0;
        if (q.ph == PH_OUTPUT && int_sck) begin
            if (q.div == 5'h00) begin
                d.div   = 5'(ISCK_HALF_CYC - 1);
                d.sck_o = ~q.sck_o; // RQ3
                rise    = ~q.sck_o;
                fall    = q.sck_o;
            end else begin
                d.div = q.div - 1'b1;
            end
        end else if (q.ph == PH_OUTPUT) begin
            d.sck_o = 1'b0;
            rise    = d.flt[PIN_SCK] & ~q.flt[PIN_SCK]; // RQ2
            fall    = ~d.flt[PIN_SCK] & q.flt[PIN_SCK];
        end else begin
            d.sck_o = 1'b0;
        end

        // Cycle sequencer
        tick = q.run_ext ? f0_rise : 1'b1;
        case (q.ph)
            PH_CONVERT: begin
                d.busy  = 1'b1; // RQ1
                d.sleep = 1'b0;
                if (q.kick) begin
                    d.kick  = 1'b0;
                    d.start = 1'b1;
                end
                // Timer waits for the start pulse so a conversion is never short
                if (q.tmr != 32'h0000_0000 && tick && !q.kick) begin
                    d.tmr = q.tmr - 1'b1;
                end
                // Done when timed out and the matching result is here
                if (q.tmr == 32'h0000_0000 && fifo_ov && !q.kick) begin
                    pop     = 1'b1;
                    d.sreg  = out_word(fifo_res); // RQ18 RQ8
                    d.busy  = 1'b0; // RQ1
                    d.sleep = 1'b1; // RQ11
                    d.ph    = PH_SLEEP; // RQ16
                end
            end
            PH_SLEEP: begin
                // Shifter is left alone so the result keeps
                d.sleep = 1'b1; // RQ11 RQ17
                if (!cs_n) begin
                    d.sleep = 1'b0; // RQ10
                    d.ph    = PH_OUTPUT; // RQ16
                    d.fcnt  = 6'h00;
                    d.rcnt  = 6'h00;
                    d.sdi_w = 32'h0000_0000;
                    d.div   = 5'(ISCK_HALF_CYC - 1);
                end
            end
            default: begin
                // Host bits are taken on rising edges
                if (rise && q.rcnt != WORD_FULL) begin
                    d.sdi_w[5'(WORD_LAST - q.rcnt)] = d.flt[PIN_SDI]; // RQ7
                    d.rcnt = q.rcnt + 1'b1;
                end
                // Data moves on falling edges
                if (fall) begin
                    d.sreg = {q.sreg[30:0], 1'b0}; // RQ19
                    d.fcnt = q.fcnt + 1'b1;
                end
                // End of frame or abort both start a conversion
                if (cs_n || (fall && q.fcnt == WORD_LAST)) begin // RQ12 RQ20
                    d.ph           = PH_CONVERT; // RQ16
                    d.busy         = 1'b1; // RQ1
                    d.sreg[BIT_EOC] = 1'b1; // RQ25
                    d.start        = 1'b1;
                    d.run_ext      = q.f0_ext; // RQ9
                    // Apply only a word that reached all its fields
                    if (d.rcnt >= SDI_MIN_BITS && d.sdi_w[SEL_EN_POS]) begin // RQ6
                        d.cfg.chan = d.sdi_w[SEL_CH_POS +: 4]; // RQ4 RQ27
                        d.cfg.gref = d.sdi_w[SEL_GREF_POS]; // RQ22
                        d.cfg.oversampling_ratio  = d.sdi_w[SEL_OSR_POS +: 3]; // RQ4
                        d.cfg.twox = d.sdi_w[SEL_TWOX_POS]; // RQ4
                    end
                    d.tmr = conv_ticks(d.cfg.oversampling_ratio, q.f0_ext);
                end
            end
        endcase

        // Pin drivers
        d.sdo_oe = ~cs_n; // RQ10 RQ13
        d.sdo_o  = (d.ph == PH_OUTPUT) ? d.sreg[BIT_EOC] : d.busy; // RQ14
        d.sck_oe = (d.ph == PH_OUTPUT) && int_sck; // RQ15
    end

    // State register; reset starts a conversion on the defaults
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            q           <= '0;
            q.ph        <= PH_CONVERT; // RQ16
            q.kick      <= 1'b1;
            q.busy      <= 1'b1;
            q.tmr       <= 32'(CONV_LEN);
            q.f0_idle   <= 8'hFF;
            q.cfg.chan  <= CH_DEFAULT; // RQ5
            q.cfg.gref  <= GREF_DEFAULT; // RQ5
            q.cfg.oversampling_ratio   <= OSR_DEFAULT; // RQ5
            q.cfg.twox  <= TWOX_DEFAULT; // RQ5
            q.sreg      <= 32'h8000_0000;
            // Select idles high so no false frame follows reset
            q.s1[PIN_CS]  <= 1'b1; // RQ13
            q.s2[PIN_CS]  <= 1'b1;
            q.s3[PIN_CS]  <= 1'b1;
            q.flt[PIN_CS] <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign SCK_O        = q.sck_o;
    assign SCK_OE       = q.sck_oe;
    assign SDO_O        = q.sdo_o;
    assign SDO_OE       = q.sdo_oe;
    assign BUSY         = q.busy;
    assign CONV_START   = q.start;
    assign CONV_CFG     = q.cfg;
    assign OSC_EXTERNAL = q.run_ext;
    assign SLEEP        = q.sleep;

endmodule // adc_cycle_ctrl

// ===== tb/adc_cycle_ctrl_properties.sv
// Port-level checker of the converter cycle controller
`timescale 1ns/1ps
// ==========================================================
module adc_cycle_ctrl_properties #(
    parameter int CONV_LEN = 20
) (
    // Clock and reset
    input wire logic                CLOCK,
    input wire logic                NRST,
    // Serial pins
    input wire logic                CS_N,
    input wire logic                SDO_O,
    input wire logic                SDO_OE,
    input wire logic                SCK_OE,
    // Cycle state
    input wire logic                BUSY,
    input wire logic                SLEEP,
    input wire logic                CONV_START,
    input wire logic                OSC_EXTERNAL,
    input wire adc_cycle_pkg::cfg_s CONV_CFG
);
    import adc_cycle_pkg::*;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    // Cycles since the last start; no saturation needed in short runs
    always_comb begin
        cnt_nxt = CONV_START ? 32'h1 : cnt_r + 32'h1;
    end
    always_ff @(posedge CLOCK) begin
        cnt_r <= NRST ? cnt_nxt : 32'h0;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // ==========================================================
    // Six cycles cover the pin synchroniser latency
    AST_SDO_OFF: assert property (CS_N [*6] |-> !SDO_OE)
        else $error("data pin driven with select high");
    AST_SDO_ON: assert property (!CS_N [*6] |-> SDO_OE)
        else $error("data pin released with select low");
    AST_STATUS_BUSY: assert property (SDO_OE && BUSY |-> SDO_O)
        else $error("status low while converting");
    AST_STATUS_SLEEP: assert property (SDO_OE && SLEEP |-> !SDO_O)
        else $error("status high in sleep");
    AST_DONE_SLEEP: assert property ($fell(BUSY) |-> SLEEP)
        else $error("busy fell without sleep");
    AST_RISE_START: assert property ($rose(BUSY) |-> CONV_START)
        else $error("busy rose without a start");
    AST_CONV_TIME: assert property ($fell(BUSY) && !OSC_EXTERNAL |->
        cnt_r >= (32'(CONV_LEN) << CONV_CFG.oversampling_ratio)) else $error("conversion too short");
    AST_CFG_HOLD: assert property (BUSY && $past(BUSY) && !CONV_START |-> $stable(CONV_CFG))
        else $error("settings moved in conversion");
    AST_SCK_DIR: assert property (SCK_OE |-> !BUSY && !SLEEP)
        else $error("clock pin driven outside output");
    AST_SLEEP_STAY: assert property ((SLEEP && CS_N) [*5] |=> SLEEP)
        else $error("left sleep with select high");
    // Main scenarios
    cover property ($rose(SCK_OE));
    cover property ($fell(BUSY));
    cover property (CONV_START && !CS_N);
endmodule // adc_cycle_ctrl_properties

bind adc_cycle_ctrl adc_cycle_ctrl_properties #(.CONV_LEN(CONV_LEN)) adc_cycle_ctrl_properties_inst (
    .CLOCK(CLOCK), .NRST(NRST), .CS_N(CS_N), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
    .SCK_OE(SCK_OE), .BUSY(BUSY), .SLEEP(SLEEP), .CONV_START(CONV_START),
    .OSC_EXTERNAL(OSC_EXTERNAL), .CONV_CFG(CONV_CFG));

// ===== tb/host_model.sv
// Host model: drives select, serial clock and serial input pins
`timescale 1ns/1ps
// ==========================================================
module host_model (
    // Clock
    input wire logic clk,
    // Pins towards the device
    output logic     cs_n,
    output logic     sck,
    output logic     sdi,
    input wire logic sck_pin,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // Serial clock stands low between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Wait for a clock pin level; bounded so a dead clock shows up
    task automatic wait_pin(input logic lvl, inout bit ok);
        int n;
        for (n = 0; n < 100 && sck_pin !== lvl; n++) @(negedge clk);
        ok &= (sck_pin === lvl);
    endtask
    // One frame; a short count aborts by raising select at once
    task automatic frame(input logic intl, input logic [31:0] sel, input int nb,
                         input bit hold, output logic [31:0] rd, output bit ok);
        int i;
        rd = 32'h0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        ok = (sdo_oe === 1'b1);
        for (i = 0; i < nb; i++) begin
            sdi = sel[31-i];
            if (intl) begin
                wait_pin(1'b1, ok);
                rd[31-i] = sdo;
                wait_pin(1'b0, ok);
            end else begin
                repeat (4) @(negedge clk);
                sck = 1'b1;
                // Sampled late in the high half to cover pin latency
                repeat (4) @(negedge clk);
                rd[31-i] = sdo;
                sck = 1'b0;
            end
        end
        sdi = ~sdi;
        if (!hold) begin
            if (nb == 32) repeat (8) @(negedge clk);
            cs_n = 1'b1;
        end
    endtask
endmodule // host_model

// ===== tb/adc_cycle_ctrl_tb.sv
// Self-checking bench of the converter cycle controller
`timescale 1ns/1ps
`define CHECK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
// ==========================================================
module adc_cycle_ctrl_tb;
    import adc_cycle_pkg::*;
    logic        clock;
    logic        nrst;
    logic        cs_n, sdi, hsck, sck_o, sck_oe, sck_pin, sdo_o, sdo_oe, busy;
    logic        sel_pin, f0, start, osc_ext, sleep, res_valid, res_ready;
    logic        sdo_pin;
    bit          f0_on;
    cfg_s        cfg;
    res_s        res_data;
    res_s        words [9];
    logic [31:0] rd;
    bit          ok;
    int          i;
    int          miscompares = 0;
    int          num_checks = 0;
    // Wire level of the two-way clock pin
    assign sck_pin = sck_oe ? sck_o : hsck;
    // Released data pin has no pull; the inverse shows up a late sample
    assign sdo_pin = sdo_oe ? sdo_o : ~sdo_o;
    // Frequency pin toggles every two clocks while enabled
    initial begin
        f0 = 1'b0;
        forever begin
            repeat (2) @(negedge clock);
            if (f0_on) f0 = ~f0;
        end
    end
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    adc_cycle_ctrl #(.CONV_LEN(20), .FIFO_DEPTH(8)) adc_cycle_ctrl_inst (
        .CLOCK(clock), .NRST(nrst), .CS_N(cs_n), .SDI(sdi), .SCK_I(sck_pin),
        .SCK_O(sck_o), .SCK_OE(sck_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .BUSY(busy),
        .SCK_SOURCE_SELECT(sel_pin), .CONVERSION_CLOCK_PIN(f0), .CONV_START(start),
        .CONV_CFG(cfg), .OSC_EXTERNAL(osc_ext), .SLEEP(sleep), .RES_VALID(res_valid),
        .RES_DATA(res_data), .RES_READY(res_ready));
    host_model host_model_inst (.clk(clock), .cs_n(cs_n), .sck(hsck), .sdi(sdi),
        .sck_pin(sck_pin), .sdo(sdo_pin), .sdo_oe(sdo_oe));
    // Data pin word for one front-end result; range flags force two bits
    function automatic logic [31:0] exp_word(input res_s r);
        logic s;
        logic m;
        s = r.over | (r.sign & ~r.under);
        m = r.over | (r.value[23] & ~r.under);
        return {2'b00, s, m, r.value[22:0], r.sub};
    endfunction
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hang(input string what);
        miscompares++;
        $display("Error %s expected done seen timeout", what);
        complete_run();
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 2000 && busy !== lvl; n++) @(negedge clock);
        if (busy !== lvl) hang("busy");
    endtask
    // Offer one result and hold it until taken
    task automatic push(input res_s r);
        int n;
        @(negedge clock);
        res_data = r;
        res_valid = 1'b1;
        for (n = 0; n < 200 && res_ready !== 1'b1; n++) @(negedge clock);
        @(negedge clock);
        res_valid = 1'b0;
        if (n == 200) hang("push");
    endtask
    // Frames start only once the result is ready
    task automatic xfer(input logic intl, input logic [31:0] sel, input int nb, input bit hold);
        wait_busy(1'b0);
        host_model_inst.frame(intl, sel, nb, hold, rd, ok);
        if (!ok) hang("frame");
    endtask
    // ==========================================================
    initial begin
        nrst = 1'b0;
        sel_pin = 1'b0;
        res_valid = 1'b0;
        res_data = '0;
        for (i = 0; i < 9; i++) words[i] = '{sign: i[0], value: 24'hC35A00 ^ {i[7:0], 16'h0},
            sub: 5'h15 ^ i[4:0], over: i == 3, under: i == 5};
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        `CHECK("cfg", cfg, 9'h000)
        `CHECK("busy", busy, 1'b1)
        `CHECK("osc", osc_ext, 1'b0)
        `CHECK("sdo_oe_rst", sdo_oe, 1'b0)
        push(words[0]);
        wait_busy(1'b0);
        for (i = 1; i < 9; i++) push(words[i]);
        // Ninth word offered to a full buffer must be refused
        @(negedge clock);
        res_valid = 1'b1;
        repeat (20) @(negedge clock);
        `CHECK("ready", res_ready, 1'b0)
        `CHECK("sleep", sleep, 1'b1)
        res_valid = 1'b0;
        $display("Test fill done");
        xfer(1'b0, {1'b1, 1'b1, 4'h5, 3'h1, 1'b0, 22'h0}, 32, 1'b1);
        `CHECK("word0", rd, exp_word(words[0]))
        repeat (8) @(negedge clock);
        `CHECK("sdo_end", sdo_o, 1'b1)
        `CHECK("busy_new", busy, 1'b1)
        `CHECK("cfg_new", cfg, 9'h0B2)
        wait_busy(1'b0);
        `CHECK("sdo_done", sdo_o, 1'b0)
        xfer(1'b0, {1'b0, 1'b0, 4'h7, 3'h2, 1'b1, 22'h3FFFFF}, 32, 1'b0);
        `CHECK("word1", rd, exp_word(words[1]))
        repeat (8) @(negedge clock);
        `CHECK("cfg_kept", cfg, 9'h0B2)
        $display("Test external frames done");
        xfer(1'b0, {1'b1, 1'b0, 4'h2, 3'h0, 1'b0, 22'h0}, 5, 1'b0);
        `CHECK("part", rd >> 27, exp_word(words[2]) >> 27)
        repeat (6) @(negedge clock);
        `CHECK("abort", busy, 1'b1)
        `CHECK("cfg_abort", cfg, 9'h0B2)
        $display("Test abort done");
        sel_pin = 1'b1;
        xfer(1'b1, {1'b1, 1'b0, 4'h3, 3'h0, 1'b1, 22'h0}, 32, 1'b0);
        `CHECK("word3", rd, exp_word(words[3]))
        repeat (8) @(negedge clock);
        `CHECK("cfg_int", cfg, 9'h061)
        sel_pin = 1'b0;
        $display("Test internal clock done");
        for (i = 4; i < 9; i++) begin
            xfer(1'b0, 32'h0, 32, 1'b0);
            `CHECK("word", rd, exp_word(words[i]))
        end
        repeat (8) @(negedge clock);
        `CHECK("drained", res_ready, 1'b1)
        repeat (300) @(negedge clock);
        `CHECK("no_result", busy, 1'b1)
        $display("Test drain done");
        // A toggling frequency pin at frame end selects external timing
        f0_on = 1'b1;
        push(words[0]);
        xfer(1'b0, 32'h0, 32, 1'b0);
        repeat (8) @(negedge clock);
        `CHECK("osc_ext", osc_ext, 1'b1)
        `CHECK("busy_ext", busy, 1'b1)
        f0_on = 1'b0;
        $display("Test frequency pin done");
        complete_run();
    end
endmodule // adc_cycle_ctrl_tb
